// >>> hw/motor_startup_config_reg.v
// Start-up configuration register and its decoded settings.
// Assumes all inputs come from logic on SYS_CLK_IN; no synchronisers needed.
`timescale 1ns/1ps
`include "startup_cfg_defines.vh"

module motor_startup_config_reg #(
    parameter CLK_HZ = `CLK_HZ
) (
    input  wire        SYS_CLK_IN,
    input  wire        RESETN_IN,
    input  wire [7:0]  REG_ADDR_IN,
    input  wire [31:0] REG_WDATA_IN,
    input  wire        REG_WR_IN,
    input  wire        REG_RD_IN,
    input  wire [3:0]  OPEN_LOOP_CURRENT_CAP_CODE_IN,
    input  wire [22:0] GENERAL_CURRENT_CAP_IN,
    input  wire [1:0]  REV_OPEN_LOOP_CURRENT_CODE_IN,
    input  wire [3:0]  FWD_ACCEL_A1_CODE_IN,
    input  wire [3:0]  REV_ACCEL_A1_CODE_IN,
    input  wire [3:0]  FWD_ACCEL_A2_CODE_IN,
    input  wire [3:0]  REV_ACCEL_A2_CODE_IN,
    output reg  [31:0] REG_RDATA_OUT,
    output reg  [3:0]  START_METHOD_ONEHOT_OUT,
    output reg  [22:0] RAMP_RATE_OUT,
    output reg         RAMP_UNLIMITED_OUT,
    output reg  [13:0] ALIGN_TIME_MS_OUT,
    output reg  [22:0] STARTUP_CURRENT_CAP_OUT,
    output reg  [13:0] PROBE_PULSE_RATE_OUT,
    output reg         PROBE_PULSE_TICK_OUT,
    output reg  [22:0] PROBE_THRESHOLD_OUT,
    output reg         PROBE_THRESHOLD_INVALID_OUT,
    output reg         PROBE_RELEASE_TRISTATE_OUT,
    output reg  [6:0]  ADVANCE_ANGLE_DEG_OUT,
    output reg  [2:0]  PROBE_RUNS_OUT,
    output reg  [22:0] OPEN_LOOP_CURRENT_CAP_OUT,
    output reg  [23:0] ACCEL_A1_OUT,
    output reg  [3:0]  ACCEL_A2_CODE_OUT,
    output reg         RAMPDOWN_ENABLE_OUT,
    output reg         ACTIVE_BRAKE_ENABLE_OUT,
    output reg         REVERSE_SOURCE_OUT
);

    // ----------------------------------------------------------------
    // Lookup functions (currents in uA, ramp in mA/s, A1 in mHz/s)
    // ----------------------------------------------------------------
    // Shared by the start-up cap and the open-loop cap tables
    function [22:0] cap_ua;
        input [3:0] code;
        begin
            case (code)
                4'h0: cap_ua = 23'd78125;
                4'h1: cap_ua = 23'd156250;
                4'h2: cap_ua = 23'd312500;
                4'h3: cap_ua = 23'd625000;
                4'h4: cap_ua = 23'd937500;
                4'h5: cap_ua = 23'd1250000;
                4'h6: cap_ua = 23'd1562500;
                4'h7: cap_ua = 23'd1875000;
                4'h8: cap_ua = 23'd2187500;
                4'h9: cap_ua = 23'd2500000;
                4'hA: cap_ua = 23'd2812500;
                4'hB: cap_ua = 23'd3125000;
                4'hC: cap_ua = 23'd3437500;
                4'hD: cap_ua = 23'd3750000;
                4'hE: cap_ua = 23'd4375000;
                default: cap_ua = 23'd5000000;
            endcase
        end
    endfunction

    // Used for both forward and reverse A1
    function [23:0] accel_mhz;
        input [3:0] code;
        begin
            case (code)
                4'h0: accel_mhz = 24'd10;
                4'h1: accel_mhz = 24'd50;
                4'h2: accel_mhz = 24'd1000;
                4'h3: accel_mhz = 24'd2500;
                4'h4: accel_mhz = 24'd5000;
                4'h5: accel_mhz = 24'd10000;
                4'h6: accel_mhz = 24'd25000;
                4'h7: accel_mhz = 24'd50000;
                4'h8: accel_mhz = 24'd75000;
                4'h9: accel_mhz = 24'd100000;
                4'hA: accel_mhz = 24'd250000;
                4'hB: accel_mhz = 24'd500000;
                4'hC: accel_mhz = 24'd750000;
                4'hD: accel_mhz = 24'd1000000;
                4'hE: accel_mhz = 24'd5000000;
                default: accel_mhz = 24'd10000000;
            endcase
        end
    endfunction

    function [22:0] ramp_ma;
        input [3:0] code;
        begin
            case (code)
                4'h0: ramp_ma = 23'd100;
                4'h1: ramp_ma = 23'd1000;
                4'h2: ramp_ma = 23'd5000;
                4'h3: ramp_ma = 23'd10000;
                4'h4: ramp_ma = 23'd15000;
                4'h5: ramp_ma = 23'd25000;
                4'h6: ramp_ma = 23'd50000;
                4'h7: ramp_ma = 23'd100000;
                4'h8: ramp_ma = 23'd150000;
                4'h9: ramp_ma = 23'd200000;
                4'hA: ramp_ma = 23'd250000;
                4'hB: ramp_ma = 23'd500000;
                4'hC: ramp_ma = 23'd1000000;
                4'hD: ramp_ma = 23'd2000000;
                4'hE: ramp_ma = 23'd5000000;
                default: ramp_ma = 23'h7F_FFFF;
            endcase
        end
    endfunction

    function [13:0] align_ms;
        input [3:0] code;
        begin
            case (code)
                4'h0: align_ms = 14'd10;
                4'h1: align_ms = 14'd50;
                4'h2: align_ms = 14'd100;
                4'h3: align_ms = 14'd200;
                4'h4: align_ms = 14'd300;
                4'h5: align_ms = 14'd400;
                4'h6: align_ms = 14'd500;
                4'h7: align_ms = 14'd750;
                4'h8: align_ms = 14'd1000;
                4'h9: align_ms = 14'd1500;
                4'hA: align_ms = 14'd2000;
                4'hB: align_ms = 14'd3000;
                4'hC: align_ms = 14'd4000;
                4'hD: align_ms = 14'd5000;
                4'hE: align_ms = 14'd7500;
                default: align_ms = 14'd10000;
            endcase
        end
    endfunction

    function [13:0] pulse_hz;
        input [2:0] code;
        begin
            case (code)
                3'h0: pulse_hz = 14'd50;
                3'h1: pulse_hz = 14'd100;
                3'h2: pulse_hz = 14'd250;
                3'h3: pulse_hz = 14'd500;
                3'h4: pulse_hz = 14'd1000;
                3'h5: pulse_hz = 14'd2000;
                3'h6: pulse_hz = 14'd5000;
                default: pulse_hz = 14'd10000;
            endcase
        end
    endfunction

    // Divider period per pulse rate; constant divisions only
    function [31:0] pulse_period;
        input [2:0] code;
        begin
            case (code)
                3'h0: pulse_period = CLK_HZ / 50;
                3'h1: pulse_period = CLK_HZ / 100;
                3'h2: pulse_period = CLK_HZ / 250;
                3'h3: pulse_period = CLK_HZ / 500;
                3'h4: pulse_period = CLK_HZ / 1000;
                3'h5: pulse_period = CLK_HZ / 2000;
                3'h6: pulse_period = CLK_HZ / 5000;
                default: pulse_period = CLK_HZ / 10000;
            endcase
        end
    endfunction

    function [22:0] threshold_ua;
        input [4:0] code;
        begin
            case (code)
                5'h00: threshold_ua = 23'd156250;
                5'h01: threshold_ua = 23'd312500;
                5'h02: threshold_ua = 23'd468000;
                5'h03: threshold_ua = 23'd625000;
                5'h04: threshold_ua = 23'd781250;
                5'h05: threshold_ua = 23'd937500;
                5'h06: threshold_ua = 23'd1250000;
                5'h07: threshold_ua = 23'd1562500;
                5'h08: threshold_ua = 23'd1875000;
                5'h09: threshold_ua = 23'd2291000;
                5'h0A: threshold_ua = 23'd2500000;
                5'h0B: threshold_ua = 23'd2916000;
                5'h0C: threshold_ua = 23'd3125000;
                5'h0D: threshold_ua = 23'd3333000;
                5'h0E: threshold_ua = 23'd3750000;
                5'h0F: threshold_ua = 23'd4166000;
                5'h10: threshold_ua = 23'd4583000;
                5'h11: threshold_ua = 23'd5000000;
                default: threshold_ua = 23'd0;
            endcase
        end
    endfunction

    function [22:0] rev_cap_ua;
        input [1:0] code;
        begin
            case (code)
                2'h0: rev_cap_ua = 23'd937500;
                2'h1: rev_cap_ua = 23'd1562500;
                2'h2: rev_cap_ua = 23'd2187500;
                default: rev_cap_ua = 23'd3125000;
            endcase
        end
    endfunction

    // Advance angle in whole degrees; a table avoids a narrow product
    function [6:0] advance_deg;
        input [1:0] code;
        begin
            case (code)
                2'h0: advance_deg = 7'd0;
                2'h1: advance_deg = 7'd30;
                2'h2: advance_deg = 7'd60;
                default: advance_deg = 7'd90;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Register write and read port
    // ----------------------------------------------------------------
    reg  [31:0] settings;
    reg  [21:0] pulse_count;
    wire        hit_settings = (REG_ADDR_IN == `STARTUP_OFFSET);
    wire        hit_status   = (REG_ADDR_IN == `STATUS_OFFSET);
    wire        threshold_bad = (settings[`F_THRESHOLD] > `THRESHOLD_LAST);
    wire        probe_method  = (settings[`F_METHOD] == `METHOD_PROBE);
    // Status bits other than the limit-source bit use the registered outputs, so they lag one cycle
    wire [31:0] status_word = {24'h00_0000, REVERSE_SOURCE_OUT,
                               settings[`B_LIMIT_SOURCE], START_METHOD_ONEHOT_OUT,
                               RAMP_UNLIMITED_OUT, PROBE_THRESHOLD_INVALID_OUT};

    // Only the settings word is writable; status is read-only
    always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            settings <= `STARTUP_RESET;
        end else if (REG_WR_IN && hit_settings) begin
            settings <= REG_WDATA_IN & `WRITABLE_MASK;
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads zero
    always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            REG_RDATA_OUT <= 32'h0000_0000;
        end else if (REG_RD_IN && hit_settings) begin
            REG_RDATA_OUT <= settings;
        end else if (REG_RD_IN && hit_status) begin
            REG_RDATA_OUT <= status_word;
        end else begin
            REG_RDATA_OUT <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Decoded settings, all registered
    // ----------------------------------------------------------------
    // Outputs follow settings one cycle after the write lands
    always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            START_METHOD_ONEHOT_OUT     <= 4'h1;
            RAMP_RATE_OUT               <= 23'd100;
            RAMP_UNLIMITED_OUT          <= 1'b0;
            ALIGN_TIME_MS_OUT           <= 14'd10;
            STARTUP_CURRENT_CAP_OUT     <= 23'd78125;
            PROBE_PULSE_RATE_OUT        <= 14'd50;
            PROBE_THRESHOLD_OUT         <= 23'd156250;
            PROBE_THRESHOLD_INVALID_OUT <= 1'b0;
            PROBE_RELEASE_TRISTATE_OUT  <= 1'b0;
            ADVANCE_ANGLE_DEG_OUT       <= 7'd0;
            PROBE_RUNS_OUT              <= 3'd1;
            OPEN_LOOP_CURRENT_CAP_OUT   <= 23'd0;
            ACCEL_A1_OUT                <= 24'd0;
            ACCEL_A2_CODE_OUT           <= 4'h0;
            RAMPDOWN_ENABLE_OUT         <= 1'b0;
            ACTIVE_BRAKE_ENABLE_OUT     <= 1'b0;
            REVERSE_SOURCE_OUT          <= 1'b0;
        end else begin
            START_METHOD_ONEHOT_OUT <= 4'h1 << settings[`F_METHOD];
            // No-limit code reads all ones; users must test the flag
            RAMP_RATE_OUT <= ramp_ma(settings[`F_RAMP]);
            RAMP_UNLIMITED_OUT <= (settings[`F_RAMP] == `RAMP_NO_LIMIT);
            ALIGN_TIME_MS_OUT <= align_ms(settings[`F_ALIGN_TIME]);
            STARTUP_CURRENT_CAP_OUT <= cap_ua(settings[`F_START_CAP]);
            PROBE_PULSE_RATE_OUT <= pulse_hz(settings[`F_PULSE_RATE]);
            // Invalid codes give zero, never a usable threshold
            PROBE_THRESHOLD_OUT <= threshold_ua(settings[`F_THRESHOLD]);
            PROBE_THRESHOLD_INVALID_OUT <= threshold_bad;
            PROBE_RELEASE_TRISTATE_OUT <= settings[`B_RELEASE];
            ADVANCE_ANGLE_DEG_OUT <= advance_deg(settings[`F_ADVANCE]);
            PROBE_RUNS_OUT <= {1'b0, settings[`F_REPEAT]} + 3'd1;
            // Reverse source wins over the limit-source bit
            if (settings[`B_REVERSE_SOURCE]) begin
                OPEN_LOOP_CURRENT_CAP_OUT <= rev_cap_ua(REV_OPEN_LOOP_CURRENT_CODE_IN);
                ACCEL_A1_OUT <= accel_mhz(REV_ACCEL_A1_CODE_IN);
                ACCEL_A2_CODE_OUT <= REV_ACCEL_A2_CODE_IN;
            end else begin
                if (settings[`B_LIMIT_SOURCE]) begin
                    OPEN_LOOP_CURRENT_CAP_OUT <= GENERAL_CURRENT_CAP_IN;
                end else begin
                    OPEN_LOOP_CURRENT_CAP_OUT <= cap_ua(OPEN_LOOP_CURRENT_CAP_CODE_IN);
                end
                ACCEL_A1_OUT <= accel_mhz(FWD_ACCEL_A1_CODE_IN);
                ACCEL_A2_CODE_OUT <= FWD_ACCEL_A2_CODE_IN;
            end
            RAMPDOWN_ENABLE_OUT <= settings[`B_RAMPDOWN];
            ACTIVE_BRAKE_ENABLE_OUT <= settings[`B_ACTIVE_BRAKE];
            REVERSE_SOURCE_OUT <= settings[`B_REVERSE_SOURCE];
        end
    end

    // ----------------------------------------------------------------
    // Probe pulse divider
    // ----------------------------------------------------------------
    // Runs only while the probe method is chosen, to save toggling
    // Counter width covers the slowest rate at the default clock
    always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pulse_count          <= 22'd0;
            PROBE_PULSE_TICK_OUT <= 1'b0;
        end else if (!probe_method) begin
            pulse_count          <= 22'd0;
            PROBE_PULSE_TICK_OUT <= 1'b0;
        end else if ({10'd0, pulse_count} + 32'd1
                     >= pulse_period(settings[`F_PULSE_RATE])) begin
            pulse_count          <= 22'd0;
            PROBE_PULSE_TICK_OUT <= 1'b1;
        end else begin
            pulse_count          <= pulse_count + 22'd1;
            PROBE_PULSE_TICK_OUT <= 1'b0;
        end
    end

endmodule // motor_startup_config_reg

// >>> hw/startup_cfg_defines.vh
// Constants for the motor start-up configuration register bank.
// Assumes a single 100 MHz clock and a simple strobed register port.
// Notes on behaviour
// - Register at 84h, cleared to zero on reset
// - Bits 30-29 pick the start method
// - Bits 28-25 set ramp rate; Fh unlimited
// - Bits 24-21 map to align duration
// - Bits 20-17 set align/slow-cycle current cap
// - Bits 16-14 set probe pulse rate
// - Bits 13-9 set probe current threshold
// - Bit 8: zero brakes, one tri-states
// - Bits 7-6 add 0/30/60/90 degrees
// - Bits 5-4 give one to four runs
// - Bit 3 picks forward open-loop cap source
// - Bit 2 enables torque-current ramp-down
// - Bit 1 enables active braking reverse drive
// - Bit 0 picks forward or reverse parameters
// - Open-loop cap code maps 0.078125-5.0 A
// - Reverse A1 code maps 0.01-10000 Hz/s
`ifndef STARTUP_CFG_DEFINES_VH
`define STARTUP_CFG_DEFINES_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_W              8
`define STARTUP_OFFSET      8'h84
`define STATUS_OFFSET       8'hC0
`define STARTUP_RESET       32'h0000_0000
`define WRITABLE_MASK       32'h7FFF_FFFF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define F_METHOD            30:29
`define F_RAMP              28:25
`define F_ALIGN_TIME        24:21
`define F_START_CAP         20:17
`define F_PULSE_RATE        16:14
`define F_THRESHOLD         13:9
`define B_RELEASE           8
`define F_ADVANCE           7:6
`define F_REPEAT            5:4
`define B_LIMIT_SOURCE      3
`define B_RAMPDOWN          2
`define B_ACTIVE_BRAKE      1
`define B_REVERSE_SOURCE    0

// ----------------------------------------------------------------
// Codes and limits
// ----------------------------------------------------------------
`define METHOD_ALIGN        2'h0
`define METHOD_DOUBLE       2'h1
`define METHOD_PROBE        2'h2
`define METHOD_SLOW         2'h3
`define RAMP_NO_LIMIT       4'hF
`define THRESHOLD_LAST      5'h11
`define CLK_HZ              100000000

`endif

// >>> tb/motor_startup_config_reg_properties.sv
// Checker for the start-up configuration register bank.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`include "startup_cfg_defines.vh"

module startup_cfg_checker (
    input wire        SYS_CLK_IN,
    input wire        RESETN_IN,
    input wire [7:0]  REG_ADDR_IN,
    input wire [31:0] REG_WDATA_IN,
    input wire        REG_WR_IN,
    input wire        REG_RD_IN,
    input wire [31:0] REG_RDATA_OUT,
    input wire [3:0]  START_METHOD_ONEHOT_OUT,
    input wire        RAMP_UNLIMITED_OUT,
    input wire        PROBE_PULSE_TICK_OUT,
    input wire [22:0] PROBE_THRESHOLD_OUT,
    input wire        PROBE_THRESHOLD_INVALID_OUT,
    input wire        PROBE_RELEASE_TRISTATE_OUT,
    input wire [6:0]  ADVANCE_ANGLE_DEG_OUT,
    input wire [2:0]  PROBE_RUNS_OUT,
    input wire        RAMPDOWN_ENABLE_OUT,
    input wire        ACTIVE_BRAKE_ENABLE_OUT,
    input wire        REVERSE_SOURCE_OUT
);
    default clocking dc @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    // ----------------------------------------
    // Last written word
    // ----------------------------------------
    logic [31:0] wd;
    always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            wd <= 32'h0000_0000;
        end else if (REG_WR_IN && REG_ADDR_IN == `STARTUP_OFFSET) begin
            wd <= REG_WDATA_IN;
        end
    end

    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence s_write;
        REG_WR_IN && REG_ADDR_IN == `STARTUP_OFFSET;
    endsequence
    // No second write, so wd still holds the word being decoded
    sequence s_settled;
        s_write ##1 !REG_WR_IN;
    endsequence
    sequence s_read;
        REG_RD_IN && !REG_WR_IN && REG_ADDR_IN == `STARTUP_OFFSET;
    endsequence

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_write_read_back: assert property (s_write ##1 s_read |=>
        REG_RDATA_OUT == {1'b0, wd[30:0]}) else $error("read back differs from write");
    a_top_bit_zero: assert property (REG_RDATA_OUT[31] == 1'b0)
        else $error("top bit read as one");
    a_method_decode: assert property (s_settled |=>
        START_METHOD_ONEHOT_OUT == 4'h1 << wd[30:29]) else $error("method decode wrong");
    a_ramp_flag: assert property (s_settled |=>
        RAMP_UNLIMITED_OUT == (wd[28:25] == 4'hF)) else $error("ramp flag wrong");
    a_threshold_flag: assert property (s_settled |=>
        PROBE_THRESHOLD_INVALID_OUT == (wd[13:9] > 5'h11)) else $error("threshold flag wrong");
    a_invalid_unused: assert property (PROBE_THRESHOLD_INVALID_OUT |->
        PROBE_THRESHOLD_OUT == 23'h00_0000) else $error("invalid threshold used");
    a_probe_fields: assert property (s_settled |=>
        PROBE_RELEASE_TRISTATE_OUT == wd[8] && ADVANCE_ANGLE_DEG_OUT == 7'd30 * wd[7:6]
        && PROBE_RUNS_OUT == wd[5:4] + 3'd1) else $error("probe fields wrong");
    a_enable_bits: assert property (s_settled |=>
        {RAMPDOWN_ENABLE_OUT, ACTIVE_BRAKE_ENABLE_OUT, REVERSE_SOURCE_OUT} == wd[2:0])
        else $error("enable bits wrong");
    a_rdata_idle: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 32'h0000_0000)
        else $error("read data without read");
    a_unmapped_zero: assert property (REG_RD_IN && REG_ADDR_IN != `STARTUP_OFFSET
        && REG_ADDR_IN != `STATUS_OFFSET |=> REG_RDATA_OUT == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_tick_single: assert property (PROBE_PULSE_TICK_OUT |=> !PROBE_PULSE_TICK_OUT)
        else $error("tick longer than one cycle");
endmodule // startup_cfg_checker

bind motor_startup_config_reg startup_cfg_checker chk_u (.*);

// >>> tb/tb_motor_startup_config_reg.sv
// Self-checking bench for the start-up configuration register bank.
// Assumes the checker is bound in; the bench drives every design input.
`timescale 1ns/1ps
`include "startup_cfg_defines.vh"

module tb_motor_startup_config_reg;
    // Shortened clock rate keeps probe tick gaps small
    localparam int HZ = 100000;
    logic SYS_CLK_IN = 0, RESETN_IN = 0, REG_WR_IN = 0, REG_RD_IN = 0;
    logic [7:0] REG_ADDR_IN = 0;
    logic [31:0] REG_WDATA_IN = 0, REG_RDATA_OUT;
    logic [3:0] OPEN_LOOP_CURRENT_CAP_CODE_IN = 0, FWD_ACCEL_A1_CODE_IN = 0;
    logic [3:0] REV_ACCEL_A1_CODE_IN = 0, FWD_ACCEL_A2_CODE_IN = 0, REV_ACCEL_A2_CODE_IN = 0;
    logic [22:0] GENERAL_CURRENT_CAP_IN = 0;
    logic [1:0] REV_OPEN_LOOP_CURRENT_CODE_IN = 0;
    logic [3:0] START_METHOD_ONEHOT_OUT, ACCEL_A2_CODE_OUT;
    logic [22:0] RAMP_RATE_OUT, STARTUP_CURRENT_CAP_OUT, PROBE_THRESHOLD_OUT;
    logic [22:0] OPEN_LOOP_CURRENT_CAP_OUT;
    logic [13:0] ALIGN_TIME_MS_OUT, PROBE_PULSE_RATE_OUT;
    logic [6:0] ADVANCE_ANGLE_DEG_OUT;
    logic [2:0] PROBE_RUNS_OUT;
    logic [23:0] ACCEL_A1_OUT;
    logic RAMP_UNLIMITED_OUT, PROBE_PULSE_TICK_OUT, PROBE_THRESHOLD_INVALID_OUT;
    logic PROBE_RELEASE_TRISTATE_OUT, RAMPDOWN_ENABLE_OUT, ACTIVE_BRAKE_ENABLE_OUT;
    logic REVERSE_SOURCE_OUT;
    int bad_count = 0, compares = 0, cycles = 0;
    int ramp_t[16] = '{100, 1000, 5000, 10000, 15000, 25000, 50000, 100000, 150000,
        200000, 250000, 500000, 1000000, 2000000, 5000000, 32'h7F_FFFF};
    int align_t[16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 1500, 2000, 3000,
        4000, 5000, 7500, 10000};
    int cap_t[16] = '{78125, 156250, 312500, 625000, 937500, 1250000, 1562500, 1875000,
        2187500, 2500000, 2812500, 3125000, 3437500, 3750000, 4375000, 5000000};
    int a1_t[16] = '{10, 50, 1000, 2500, 5000, 10000, 25000, 50000, 75000, 100000,
        250000, 500000, 750000, 1000000, 5000000, 10000000};
    int rate_t[8] = '{50, 100, 250, 500, 1000, 2000, 5000, 10000};
    int rev_t[4] = '{937500, 1562500, 2187500, 3125000};

    motor_startup_config_reg #(.CLK_HZ(HZ)) dut_u (.*);

    always #5 SYS_CLK_IN = ~SYS_CLK_IN;
    always @(posedge SYS_CLK_IN) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            close_out();
        end
    end

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Never called twice in a row, so the strobe is not driven twice at one time
    task automatic wr(logic [7:0] a, logic [31:0] d);
        REG_ADDR_IN <= a;
        REG_WDATA_IN <= d;
        REG_WR_IN <= 1'b1;
        @(posedge SYS_CLK_IN);
        REG_WR_IN <= 1'b0;
    endtask
    task automatic rchk(string what, logic [7:0] a, logic [31:0] exp);
        REG_ADDR_IN <= a;
        REG_RD_IN <= 1'b1;
        @(posedge SYS_CLK_IN);
        REG_RD_IN <= 1'b0;
        #1 chk(what, exp, REG_RDATA_OUT);
    endtask
    task automatic tick_gap(logic [2:0] r, int hz);
        int n;
        wr(8'h84, {1'b0, 2'h2, 12'h000, r, 14'h0000});
        // Step off the edge so a tick launched there is not taken early
        #1;
        n = 0;
        while (PROBE_PULSE_TICK_OUT !== 1'b1 && n < 3000) begin
            @(posedge SYS_CLK_IN);
            #1 n++;
        end
        n = 0;
        do begin
            @(posedge SYS_CLK_IN);
            #1 n++;
        end while (PROBE_PULSE_TICK_OUT !== 1'b1 && n < 3000);
        chk("tick gap", HZ / hz, n);
    endtask
    task automatic close_out;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin : main
        logic [3:0] k;
        logic [4:0] t;
        logic [31:0] d;
        repeat (2) @(posedge SYS_CLK_IN);
        RESETN_IN <= 1'b1;
        rchk("settings", 8'h84, 32'h0000_0000);
        chk("method", 4'h1, START_METHOD_ONEHOT_OUT);
        chk("threshold", 156250, PROBE_THRESHOLD_OUT);
        chk("runs", 1, PROBE_RUNS_OUT);
        $display("test reset done");
        for (int c = 0; c < 16; c++) begin
            k = c;
            t = {k, 1'b1};
            OPEN_LOOP_CURRENT_CAP_CODE_IN <= ~k;
            GENERAL_CURRENT_CAP_IN <= 23'h12_3456;
            REV_OPEN_LOOP_CURRENT_CODE_IN <= k[1:0];
            FWD_ACCEL_A1_CODE_IN <= k;
            REV_ACCEL_A1_CODE_IN <= ~k;
            FWD_ACCEL_A2_CODE_IN <= k;
            REV_ACCEL_A2_CODE_IN <= ~k;
            d = {k[0], k[1:0], k, k, k, k[2:0], t, k[0], k[1:0], k[3:2], k};
            wr(8'h84, d);
            rchk("settings", 8'h84, {1'b0, d[30:0]});
            chk("method", 4'h1 << k[1:0], START_METHOD_ONEHOT_OUT);
            chk("ramp", ramp_t[k], RAMP_RATE_OUT);
            chk("unlimited", k == 4'hF, RAMP_UNLIMITED_OUT);
            chk("align", align_t[k], ALIGN_TIME_MS_OUT);
            chk("start cap", cap_t[k], STARTUP_CURRENT_CAP_OUT);
            chk("rate", rate_t[k[2:0]], PROBE_PULSE_RATE_OUT);
            chk("invalid", t > 5'h11, PROBE_THRESHOLD_INVALID_OUT);
            if (t == 5'h11) chk("threshold", 5000000, PROBE_THRESHOLD_OUT);
            if (t > 5'h11) chk("threshold", 0, PROBE_THRESHOLD_OUT);
            chk("release", k[0], PROBE_RELEASE_TRISTATE_OUT);
            chk("angle", 30 * k[1:0], ADVANCE_ANGLE_DEG_OUT);
            chk("runs", k[3:2] + 1, PROBE_RUNS_OUT);
            chk("ol cap", k[0] ? rev_t[k[1:0]] : k[3] ? 32'h12_3456 : cap_t[~k],
                OPEN_LOOP_CURRENT_CAP_OUT);
            chk("a1", a1_t[k[0] ? ~k : k], ACCEL_A1_OUT);
            chk("a2", k[0] ? 4'(~k) : k, ACCEL_A2_CODE_OUT);
            chk("enables", k[2:0], {RAMPDOWN_ENABLE_OUT, ACTIVE_BRAKE_ENABLE_OUT,
                REVERSE_SOURCE_OUT});
        end
        $display("test field decode done");
        wr(8'h84, 32'hFFFF_FFFF);
        rchk("settings", 8'h84, 32'h7FFF_FFFF);
        wr(8'h90, 32'h0000_0000);
        rchk("settings", 8'h84, 32'h7FFF_FFFF);
        wr(8'hC0, 32'h0000_0000);
        rchk("status", 8'hC0, 32'h0000_00E3);
        rchk("unmapped", 8'h90, 32'h0000_0000);
        $display("test refused access done");
        tick_gap(3'h7, 10000);
        tick_gap(3'h0, 50);
        $display("test probe tick done");
        // Reset in mid-run must clear the word again
        RESETN_IN <= 1'b0;
        @(posedge SYS_CLK_IN);
        RESETN_IN <= 1'b1;
        rchk("settings", 8'h84, 32'h0000_0000);
        chk("method", 4'h1, START_METHOD_ONEHOT_OUT);
        $display("test second reset done");
        close_out();
    end
endmodule // tb_motor_startup_config_reg
